// File: hdl/dess_sequencer.sv
// Drive enable and stop sequencer: torque gating, wait times, halts,
// supply cut on emergency stop, absolute position transfer.
// Assumes one 40 MHz clock; enable, stop, mains, send request and selector pins are asynchronous and synchronised here.
`timescale 1ns/10ps
`include "dess_consts.svh"

module dess_sequencer #(
    parameter int unsigned TICK_CYCLES = `DESS_TICK_CYCLES,
    parameter int unsigned PULSE_HALF = `DESS_PULSE_CYCLES,
    parameter int POS_W = 24
) (
    input logic CLK_I,
    input logic RST_B_I,
    input logic [7:0] ADDR_I,
    input logic [31:0] WDATA_I,
    input logic WR_I,
    input logic RD_I,
    output logic [31:0] RDATA_O,
    input logic HW_AXIS_ENABLE_I,
    input logic ESTOP_B_I,
    input logic MAINS_OK_I,
    input logic POSITION_SEND_REQUEST_I,
    input logic [3:0] TRIP_DELAY_SELECTOR_I,
    input logic ALL_AXES_HALTED_I,
    input logic AXIS_STANDSTILL_I,
    input logic DEVICE_READY_I,
    input logic [POS_W-1:0] ABS_POS_I,
    output logic INTERNAL_TORQUE_ENABLE_O,
    output logic SETPOINT_ENABLE_O,
    output logic HALT_REQUEST_O,
    output dess_pkg::dess_halt_mode_t HALT_MODE_O,
    output logic SPEED_CONTROL_O,
    output logic SUPPLY_POWER_ON_O,
    output logic UNDERVOLTAGE_OUTPUT_O,
    output logic DCLINK_CONTROL_O,
    output logic READY_RELAY_O,
    output logic TRANSFER_DONE_RELAY_O,
    output logic ENC_PULSE_O
);
    import dess_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int DW = $clog2(PULSE_HALF + 1);

    typedef struct packed {
        dess_axis_state_t state;
        logic drv_on;
        logic drv_en;
        logic drv_hold;
        dess_halt_mode_t halt_mode;
        logic [1:0] loss_sel;
        logic ring;
        logic stop_en;
        logic [15:0] on_wait;
        logic [15:0] off_wait;
        logic [15:0] en_delay;
        logic [15:0] stop_max;
        logic [31:0] rdata;
        logic [TW-1:0] tick_cnt;
        logic tick;
        logic hw_en_q;
        logic estop_q;
        logic req_q;
        logic [2:0] boot_cnt;
        logic sel_loaded;
        logic sel_fault;
        logic [3:0] trip_sel;
        logic halt_latch;
        logic power_cut;
        logic ready;
        logic xfer_started;
        logic xfer_busy;
        logic xfer_done;
        logic [POS_W-1:0] pulse_left;
        logic [DW-1:0] div_cnt;
        logic enc_pulse;
    } dess_seq_state_t;

    localparam dess_seq_state_t ST_RST = '{
        state: S_OFF,
        halt_mode: DESS_HALT_SHORTEST,
        loss_sel: `DESS_LOSS_HALT,
        on_wait: `DESS_RST_ON_WAIT,
        off_wait: `DESS_RST_OFF_WAIT,
        en_delay: `DESS_RST_EN_DELAY,
        stop_max: `DESS_RST_STOP_MAX,
        default: '0
    };

    dess_seq_state_t st;
    dess_seq_state_t next_st;

    // ============================================================
    // Pin synchronisation
    logic [7:0] pins_s;
    logic hw_en;
    logic estop;
    logic mains;
    logic send_req;
    logic [3:0] sel;

    dess_sync3 #(
        .W(8)
    ) u_sync (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        // Stop pin inverted ahead of the filter, so reset reads as no stop
        .pin_i({TRIP_DELAY_SELECTOR_I, POSITION_SEND_REQUEST_I, MAINS_OK_I,
                ~ESTOP_B_I, HW_AXIS_ENABLE_I}),
        .level_o(pins_s)
    );

    assign hw_en = pins_s[0];
    assign estop = pins_s[1];
    assign mains = pins_s[2];
    assign send_req = pins_s[3];
    assign sel = pins_s[7:4];

    // ============================================================
    // Interval timers
    logic en_load;
    logic wait_load;
    logic trip_load;
    logic stop_load;
    logic [15:0] wait_val;
    logic [15:0] trip_val;
    logic en_done;
    logic wait_done;
    logic trip_done;
    logic stop_done;

    dess_interval_timer #(
        .W(16)
    ) u_en_tmr (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .load_i(en_load),
        .value_i(st.en_delay),
        .tick_i(st.tick),
        .done_o(en_done)
    );

    dess_interval_timer #(
        .W(16)
    ) u_wait_tmr (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .load_i(wait_load),
        .value_i(wait_val),
        .tick_i(st.tick),
        .done_o(wait_done)
    );

    dess_interval_timer #(
        .W(16)
    ) u_trip_tmr (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .load_i(trip_load),
        .value_i(trip_val),
        .tick_i(st.tick),
        .done_o(trip_done)
    );

    dess_interval_timer #(
        .W(16)
    ) u_stop_tmr (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .load_i(stop_load),
        .value_i(st.stop_max),
        .tick_i(st.tick),
        .done_o(stop_done)
    );

    // ============================================================
    // Command decode
    logic int_en;
    logic on_cmd;
    logic hold_cmd;
    logic loss_halt;
    logic coast;
    logic stop_req;
    logic xfer_start;

    // Edge qualifier keeps a stale zero count from enabling early
    assign int_en = hw_en & st.hw_en_q & en_done;
    assign on_cmd = st.drv_en & st.drv_on;
    assign hold_cmd = st.drv_en & st.drv_hold;
    assign loss_halt = ~st.ring & (st.loss_sel == `DESS_LOSS_HALT);
    assign coast = ~st.drv_en | (~int_en & ~loss_halt) | st.power_cut;
    assign stop_req = ~on_cmd | st.halt_latch | ~int_en;
    assign trip_val = 16'(st.trip_sel) * `DESS_MS_PER_S;
    assign xfer_start = send_req & ~st.req_q & st.ready
                        & ~st.xfer_started & ~st.xfer_done;

    // ============================================================
    // Next-state logic
    always_comb
    begin
        next_st = st;
        en_load = 1'b0;
        wait_load = 1'b0;
        stop_load = 1'b0;
        wait_val = st.on_wait;

        next_st.tick = 1'b0;
        if (st.tick_cnt == TW'(TICK_CYCLES - 1))
        begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end
        else
            next_st.tick_cnt = st.tick_cnt + 1'b1;

        next_st.hw_en_q = hw_en;
        next_st.estop_q = estop;
        next_st.req_q = send_req;
        next_st.ready = DEVICE_READY_I;
        en_load = hw_en & ~st.hw_en_q;
        trip_load = estop & ~st.estop_q;

        // Selector caught once, after the synchroniser has settled
        if (!st.sel_loaded)
        begin
            if (st.boot_cnt == 3'h4)
            begin
                next_st.sel_loaded = 1'b1;
                next_st.sel_fault = (sel == 4'h0);
                next_st.trip_sel = (sel == 4'h0) ? 4'h1 : sel;
            end
            else
                next_st.boot_cnt = st.boot_cnt + 1'b1;
        end

        if (WR_I)
        begin
            case (ADDR_I)
                `DESS_REG_CTRL:
                begin
                    next_st.drv_on = WDATA_I[`DESS_CTRL_ON];
                    next_st.drv_en = WDATA_I[`DESS_CTRL_EN];
                    next_st.drv_hold = WDATA_I[`DESS_CTRL_HOLD];
                end
                `DESS_REG_HALT:
                begin
                    next_st.halt_mode = dess_halt_mode_t'(WDATA_I[`DESS_HALT_MODE_LSB +: 2]);
                    next_st.loss_sel = WDATA_I[`DESS_HALT_LOSS_LSB +: 2];
                    next_st.ring = WDATA_I[`DESS_HALT_RING];
                    next_st.stop_en = WDATA_I[`DESS_HALT_STOP_EN];
                end
                `DESS_REG_ON_WAIT: next_st.on_wait = WDATA_I[15:0];
                `DESS_REG_OFF_WAIT: next_st.off_wait = WDATA_I[15:0];
                `DESS_REG_EN_DELAY: next_st.en_delay = WDATA_I[15:0];
                `DESS_REG_STOP_MAX: next_st.stop_max = WDATA_I[15:0];
                default: next_st.rdata = st.rdata;
            endcase
        end

        next_st.rdata = '0;
        if (RD_I)
        begin
            case (ADDR_I)
                `DESS_REG_CTRL:
                    next_st.rdata = {16'h0000, st.drv_on, st.drv_en, st.drv_hold, 13'h0000};
                `DESS_REG_HALT:
                    next_st.rdata = {26'h0000000, st.stop_en, st.ring, st.loss_sel,
                                     st.halt_mode};
                `DESS_REG_ON_WAIT: next_st.rdata = {16'h0000, st.on_wait};
                `DESS_REG_OFF_WAIT: next_st.rdata = {16'h0000, st.off_wait};
                `DESS_REG_EN_DELAY: next_st.rdata = {16'h0000, st.en_delay};
                `DESS_REG_STOP_MAX: next_st.rdata = {16'h0000, st.stop_max};
                `DESS_REG_STATUS:
                    next_st.rdata = {18'h00000, st.ready, st.xfer_done, st.xfer_busy,
                                     st.trip_sel, st.sel_fault, st.power_cut,
                                     st.halt_latch, int_en, st.state};
                default: next_st.rdata = '0;
            endcase
        end

        // Halt latch: set placed after clear so a new event wins
        if (st.state == S_OFF && !estop && mains)
            next_st.halt_latch = 1'b0;
        if ((estop || !mains) && st.state != S_OFF)
            next_st.halt_latch = 1'b1;

        // Supply stays on until all halted or trip delay expires
        if (!estop)
            next_st.power_cut = 1'b0;
        if (estop && st.estop_q && (ALL_AXES_HALTED_I || trip_done))
            next_st.power_cut = 1'b1;

        if (coast)
            next_st.state = S_OFF;
        else
        begin
            unique case (st.state)
                S_OFF:
                begin
                    if (on_cmd && int_en && !st.halt_latch && !estop && mains)
                        next_st.state = S_ON_WAIT;
                end
                S_ON_WAIT:
                begin
                    if (stop_req)
                        next_st.state = S_STOP;
                    else if (wait_done)
                        next_st.state = S_RUN;
                end
                S_RUN:
                begin
                    if (stop_req)
                        next_st.state = S_STOP;
                end
                S_STOP:
                begin
                    if (st.stop_en && stop_done)
                        next_st.state = S_OFF;
                    else if (AXIS_STANDSTILL_I)
                        next_st.state = S_OFF_WAIT;
                end
                S_OFF_WAIT:
                begin
                    if (wait_done)
                        next_st.state = S_OFF;
                end
                default: next_st.state = S_OFF;
            endcase
        end

        if (next_st.state != st.state)
        begin
            if (next_st.state == S_ON_WAIT)
                wait_load = 1'b1;
            if (next_st.state == S_OFF_WAIT)
            begin
                wait_load = 1'b1;
                wait_val = st.off_wait;
            end
            if (next_st.state == S_STOP)
                stop_load = 1'b1;
        end

        // Position transfer; ready loss after start is deliberately ignored
        if (xfer_start)
        begin
            next_st.xfer_started = 1'b1;
            next_st.xfer_busy = 1'b1;
            next_st.pulse_left = ABS_POS_I;
            next_st.div_cnt = '0;
            next_st.enc_pulse = 1'b0;
        end
        else if (st.xfer_busy)
        begin
            if (st.pulse_left == '0 && !st.enc_pulse)
            begin
                next_st.xfer_busy = 1'b0;
                next_st.xfer_done = 1'b1;
            end
            else if (st.div_cnt == DW'(PULSE_HALF - 1))
            begin
                next_st.div_cnt = '0;
                next_st.enc_pulse = ~st.enc_pulse;
                if (st.enc_pulse)
                    next_st.pulse_left = st.pulse_left - 1'b1;
            end
            else
                next_st.div_cnt = st.div_cnt + 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            st <= ST_RST;
        else
            st <= next_st;
    end

    // ============================================================
    // Outputs
    assign RDATA_O = st.rdata;
    assign INTERNAL_TORQUE_ENABLE_O = (st.state != S_OFF);
    assign SETPOINT_ENABLE_O = (st.state == S_RUN) && !hold_cmd;
    assign HALT_REQUEST_O = (st.state == S_STOP) || (st.state == S_RUN && hold_cmd);
    assign HALT_MODE_O = st.halt_mode;
    assign SPEED_CONTROL_O = st.halt_latch && st.state != S_OFF;
    assign SUPPLY_POWER_ON_O = ~st.power_cut;
    assign UNDERVOLTAGE_OUTPUT_O = mains;
    assign DCLINK_CONTROL_O = mains & on_cmd;
    assign READY_RELAY_O = st.ready;
    assign TRANSFER_DONE_RELAY_O = st.xfer_done;
    assign ENC_PULSE_O = st.enc_pulse;
endmodule : dess_sequencer

// File: hdl/dess_consts.svh
// Constants for the drive enable and stop sequencer: offsets, fields,
// reset values and timing. Assumes a 32-bit register port, byte addresses.
`ifndef DESS_CONSTS_SVH
`define DESS_CONSTS_SVH

// ============================================================
// Register offsets
`define DESS_REG_CTRL 8'h00
`define DESS_REG_HALT 8'h04
`define DESS_REG_ON_WAIT 8'h08
`define DESS_REG_OFF_WAIT 8'h0c
`define DESS_REG_EN_DELAY 8'h10
`define DESS_REG_STOP_MAX 8'h14
`define DESS_REG_STATUS 8'h18

// ============================================================
// Field positions
`define DESS_CTRL_ON 15
`define DESS_CTRL_EN 14
`define DESS_CTRL_HOLD 13
`define DESS_HALT_MODE_LSB 0
`define DESS_HALT_LOSS_LSB 2
`define DESS_HALT_RING 4
`define DESS_HALT_STOP_EN 5

// ============================================================
// Reset values and encodings
`define DESS_RST_ON_WAIT 16'h0064
`define DESS_RST_OFF_WAIT 16'h0064
`define DESS_RST_EN_DELAY 16'h0064
`define DESS_RST_STOP_MAX 16'h03e8
`define DESS_LOSS_HALT 2'h2
`define DESS_MS_PER_S 16'h03e8

// ============================================================
// Timing
`define DESS_CLK_MHZ 40
`define DESS_TICK_US 1000
`define DESS_TICK_CYCLES (`DESS_TICK_US * `DESS_CLK_MHZ)
`define DESS_PULSE_NS 500
`define DESS_PULSE_CYCLES (`DESS_PULSE_NS * `DESS_CLK_MHZ / 1000)

`endif

// File: hdl/dess_pkg.sv
// Types shared by the drive enable and stop sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package dess_pkg;

    // ============================================================
    // Halt behaviour selected per axis
    typedef enum logic [1:0] {
        DESS_HALT_SHORTEST = 2'b00,
        DESS_HALT_RAMP = 2'b01,
        DESS_HALT_SEP_RAMP = 2'b10,
        DESS_HALT_MASTER = 2'b11
    } dess_halt_mode_t;

    // ============================================================
    // Axis sequencing states
    typedef enum logic [2:0] {
        S_OFF = 3'b000,
        S_ON_WAIT = 3'b001,
        S_RUN = 3'b010,
        S_STOP = 3'b011,
        S_OFF_WAIT = 3'b100
    } dess_axis_state_t;

endpackage : dess_pkg

// File: hdl/dess_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pins; output moves once stages two and three agree.
`timescale 1ns/10ps
module dess_sync3 #(
    parameter int W = 8
) (
    input logic clk_i,
    input logic rst_b_i,
    input logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dess_sync_t;

    dess_sync_t st;
    dess_sync_t next_st;

    always_comb
    begin
        next_st.s1 = pin_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign level_o = st.q;
endmodule : dess_sync3

// File: hdl/dess_interval_timer.sv
// Reloadable down counter stepped by a shared tick.
// Assumes load and tick come from the same clock domain.
`timescale 1ns/10ps
module dess_interval_timer #(
    parameter int W = 16
) (
    input logic clk_i,
    input logic rst_b_i,
    input logic load_i,
    input logic [W-1:0] value_i,
    input logic tick_i,
    output logic done_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } dess_tmr_t;

    dess_tmr_t st;
    dess_tmr_t next_st;

    always_comb
    begin
        next_st = st;
        // Reload wins over a tick in the same cycle
        if (load_i)
            next_st.cnt = value_i;
        else if (tick_i && st.cnt != '0)
            next_st.cnt = st.cnt - 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign done_o = (st.cnt == '0);
endmodule : dess_interval_timer

// File: sim/dess_sequencer_props.sv
// Checker for the drive enable and stop sequencer, on its top ports only.
// Assumes a bench that shortens PULSE_HALF; bound after the module.
`timescale 1ns/10ps
module dess_sequencer_chk #(
    parameter int unsigned PULSE_HALF = 2
) (
    input logic CLK_I,
    input logic RST_B_I,
    input logic HW_AXIS_ENABLE_I,
    input logic ESTOP_B_I,
    input logic MAINS_OK_I,
    input logic ALL_AXES_HALTED_I,
    input logic INTERNAL_TORQUE_ENABLE_O,
    input logic SETPOINT_ENABLE_O,
    input logic HALT_REQUEST_O,
    input logic SUPPLY_POWER_ON_O,
    input logic UNDERVOLTAGE_OUTPUT_O,
    input logic TRANSFER_DONE_RELAY_O,
    input logic ENC_PULSE_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    // ============================================================
    // Helper: length of the current high phase of a pulse
    int hi_len;
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            hi_len <= 0;
        else
            hi_len <= ENC_PULSE_O ? hi_len + 1 : 0;
    end

    // ============================================================
    // Assertions
    a_setpoint_needs_torque:
        assert property (SETPOINT_ENABLE_O |-> INTERNAL_TORQUE_ENABLE_O)
        else $error("setpoints active without torque");
    a_torque_first:
        assert property ($rose(SETPOINT_ENABLE_O) |-> $past(INTERNAL_TORQUE_ENABLE_O))
        else $error("setpoints rose before torque");
    a_hw_loss_stops:
        assert property ((!HW_AXIS_ENABLE_I) [*8] |-> !SETPOINT_ENABLE_O)
        else $error("setpoints kept without hardware enable");
    a_hold_no_setpoint:
        assert property (HALT_REQUEST_O |-> !SETPOINT_ENABLE_O)
        else $error("setpoints active during halt");
    a_supply_cut:
        assert property ((!ESTOP_B_I && ALL_AXES_HALTED_I) [*8] |-> !SUPPLY_POWER_ON_O)
        else $error("supply not cut with all axes halted");
    a_undervolt_low:
        assert property ((!MAINS_OK_I) [*8] |-> !UNDERVOLTAGE_OUTPUT_O)
        else $error("undervoltage output high on mains loss");
    a_done_sticky:
        assert property (TRANSFER_DONE_RELAY_O |=> TRANSFER_DONE_RELAY_O)
        else $error("transfer done dropped");
    a_pulse_width:
        assert property ($fell(ENC_PULSE_O) |-> hi_len == PULSE_HALF)
        else $error("count pulse high time wrong");
    a_quiet_after_done:
        assert property (TRANSFER_DONE_RELAY_O |-> !ENC_PULSE_O)
        else $error("count pulse after transfer done");

    c_run: cover property ($rose(SETPOINT_ENABLE_O));
    c_cut: cover property ($fell(SUPPLY_POWER_ON_O));
    c_done: cover property ($rose(TRANSFER_DONE_RELAY_O));
endmodule : dess_sequencer_chk

bind dess_sequencer dess_sequencer_chk #(.PULSE_HALF(PULSE_HALF)) chk (
    .CLK_I(CLK_I),
    .RST_B_I(RST_B_I),
    .HW_AXIS_ENABLE_I(HW_AXIS_ENABLE_I),
    .ESTOP_B_I(ESTOP_B_I),
    .MAINS_OK_I(MAINS_OK_I),
    .ALL_AXES_HALTED_I(ALL_AXES_HALTED_I),
    .INTERNAL_TORQUE_ENABLE_O(INTERNAL_TORQUE_ENABLE_O),
    .SETPOINT_ENABLE_O(SETPOINT_ENABLE_O),
    .HALT_REQUEST_O(HALT_REQUEST_O),
    .SUPPLY_POWER_ON_O(SUPPLY_POWER_ON_O),
    .UNDERVOLTAGE_OUTPUT_O(UNDERVOLTAGE_OUTPUT_O),
    .TRANSFER_DONE_RELAY_O(TRANSFER_DONE_RELAY_O),
    .ENC_PULSE_O(ENC_PULSE_O)
);

// File: sim/dess_ctrl_model.sv
// Motion controller model: issues transfer start pulses and counts pulses.
// Assumes the same clock as the sequencer; go_i comes from the bench.
`timescale 1ns/10ps
module dess_ctrl_model (
    input logic clk_i,
    input logic rst_b_i,
    input logic go_i,
    input logic ready_i,
    input logic done_i,
    input logic pulse_i,
    output logic start_o,
    output int count_o
);
    int hold;
    logic last;
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            hold <= 0;
            start_o <= 1'b0;
            last <= 1'b0;
            count_o <= 0;
        end
        else
        begin
            // Long pulse and gap so each edge survives the pin filter
            if (hold > 0)
                hold <= hold - 1;
            else if (go_i && ready_i && !done_i)
                hold <= 16;
            start_o <= hold > 8;
            last <= pulse_i;
            if (pulse_i && !last)
                count_o <= count_o + 1;
        end
    end
endmodule : dess_ctrl_model

// File: sim/test_drive_enable_stop_sequencer.sv
// Self-checking bench for the drive enable and stop sequencer.
// Assumes shortened tick (10 cycles) and pulse half period (2 cycles).
`timescale 1ns/10ps
`include "dess_consts.svh"
module test_drive_enable_stop_sequencer;
    import dess_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic hw_en = 1'b1;
    logic estop_b = 1'b1;
    logic mains = 1'b1;
    logic halted = 1'b0;
    logic still = 1'b0;
    logic ready = 1'b0;
    logic go = 1'b0;
    logic req;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [3:0] sel = 4'h1;
    logic [23:0] pos = 24'h0;
    logic torque, setp, halt, speed, supply, uv, dcl, rdy, done, enc;
    dess_halt_mode_t mode;
    int count;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    dess_sequencer #(.TICK_CYCLES(10), .PULSE_HALF(2), .POS_W(24)) uut (
        .CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd_s), .RDATA_O(rdata), .HW_AXIS_ENABLE_I(hw_en), .ESTOP_B_I(estop_b),
        .MAINS_OK_I(mains), .POSITION_SEND_REQUEST_I(req), .TRIP_DELAY_SELECTOR_I(sel),
        .ALL_AXES_HALTED_I(halted), .AXIS_STANDSTILL_I(still), .DEVICE_READY_I(ready),
        .ABS_POS_I(pos), .INTERNAL_TORQUE_ENABLE_O(torque), .SETPOINT_ENABLE_O(setp),
        .HALT_REQUEST_O(halt), .HALT_MODE_O(mode), .SPEED_CONTROL_O(speed),
        .SUPPLY_POWER_ON_O(supply), .UNDERVOLTAGE_OUTPUT_O(uv), .DCLINK_CONTROL_O(dcl),
        .READY_RELAY_O(rdy), .TRANSFER_DONE_RELAY_O(done), .ENC_PULSE_O(enc)
    );

    dess_ctrl_model ctrl (
        .clk_i(clk), .rst_b_i(rst_b), .go_i(go), .ready_i(rdy), .done_i(done),
        .pulse_i(enc), .start_o(req), .count_o(count)
    );

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // ============================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt

    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrt

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task automatic run_up;
        wrt(`DESS_REG_CTRL, 32'hc000);
        for (int i = 0; i < 300 && setp !== 1'b1; i++) @(posedge clk);
    endtask : run_up

    task give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // ============================================================
    // Scenarios
    task t_regs;
        logic [31:0] v;
        rd(`DESS_REG_ON_WAIT, v);
        check(v, 32'h64);
        rd(`DESS_REG_HALT, v);
        check(v, 32'h8);
        rd(8'h1c, v);
        check(v, 32'h0);
        @(posedge clk);
        sel <= 4'h5;
        wt(8);
        rd(`DESS_REG_STATUS, v);
        check({27'h0, v[10:6]}, 32'h2);
        $display("t_regs done");
    endtask : t_regs

    task t_seq;
        wrt(`DESS_REG_EN_DELAY, 32'h2);
        wrt(`DESS_REG_ON_WAIT, 32'h3);
        wrt(`DESS_REG_OFF_WAIT, 32'h2);
        @(posedge clk);
        hw_en <= 1'b0;
        wrt(`DESS_REG_CTRL, 32'hc000);
        wt(10);
        check(32'(torque), 32'h0);
        hw_en <= 1'b1;
        wt(8);
        check(32'(torque), 32'h0);
        for (int i = 0; i < 200 && torque !== 1'b1; i++) @(posedge clk);
        check(32'(setp), 32'h0);
        for (int i = 0; i < 200 && setp !== 1'b1; i++) @(posedge clk);
        check(32'(setp), 32'h1);
        wrt(`DESS_REG_CTRL, 32'he000);
        wt(4);
        check({30'h0, halt, torque}, 32'h3);
        wrt(`DESS_REG_CTRL, 32'h4000);
        wt(4);
        check({30'h0, halt, torque}, 32'h3);
        still <= 1'b1;
        wt(5);
        check(32'(torque), 32'h1);
        wt(40);
        check(32'(torque), 32'h0);
        still <= 1'b0;
        $display("t_seq done");
    endtask : t_seq

    task t_modes;
        for (int m = 0; m < 4; m++)
        begin
            wrt(`DESS_REG_HALT, 32'(8 + m));
            wt(2);
            check(32'(mode), 32'(m));
        end
        run_up();
        wrt(`DESS_REG_CTRL, 32'h8000);
        wt(3);
        check(32'(torque), 32'h0);
        wt(40);
        check(32'(torque), 32'h0);
        wrt(`DESS_REG_HALT, 32'h4);
        run_up();
        hw_en <= 1'b0;
        wt(8);
        check(32'(torque), 32'h0);
        hw_en <= 1'b1;
        wrt(`DESS_REG_STOP_MAX, 32'h3);
        wrt(`DESS_REG_HALT, 32'h28);
        run_up();
        wrt(`DESS_REG_CTRL, 32'h4000);
        wt(5);
        check(32'(halt), 32'h1);
        wt(50);
        check(32'(torque), 32'h0);
        wrt(`DESS_REG_HALT, 32'h8);
        $display("t_modes done");
    endtask : t_modes

    task t_estop;
        int i;
        run_up();
        estop_b <= 1'b0;
        wt(10);
        check({30'h0, speed, halt}, 32'h3);
        check(32'(supply), 32'h1);
        halted <= 1'b1;
        wt(10);
        check({31'h0, supply}, 32'h0);
        estop_b <= 1'b1;
        halted <= 1'b0;
        wt(10);
        check(32'(supply), 32'h1);
        estop_b <= 1'b0;
        for (i = 0; i < 10200 && supply !== 1'b0; i++) @(posedge clk);
        check(32'(i > 9900 && supply === 1'b0), 32'h1);
        estop_b <= 1'b1;
        mains <= 1'b0;
        wt(10);
        check({30'h0, uv, dcl}, 32'h0);
        mains <= 1'b1;
        wt(10);
        check({30'h0, uv, dcl}, 32'h3);
        wrt(`DESS_REG_CTRL, 32'h0);
        $display("t_estop done");
    endtask : t_estop

    task t_xfer;
        @(posedge clk);
        pos <= 24'd9;
        ready <= 1'b1;
        wt(2);
        go <= 1'b1;
        wt(30);
        ready <= 1'b0;
        for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk);
        check(32'(count), 32'd9);
        wt(20);
        check(32'(done), 32'h1);
        run_up();
        check(32'(setp), 32'h1);
        $display("t_xfer done");
    endtask : t_xfer

    // ============================================================
    // Timeout and main sequence
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            give_verdict();
        end
    end

    initial
    begin
        wt(10);
        rst_b <= 1'b1;
        t_regs();
        t_seq();
        t_modes();
        t_estop();
        t_xfer();
        give_verdict();
    end
endmodule : test_drive_enable_stop_sequencer
